// >>> bped_pkg.sv
package bped_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ        = 40_000_000;
    localparam int unsigned BOOT_WIN_MS   = 200;
    localparam int unsigned BOOT_WIN_CYC  = CLK_HZ / 1000 * BOOT_WIN_MS;
    localparam int unsigned LED_PERIOD_MS = 2000;
    localparam int unsigned LED_PERIOD_CYC = CLK_HZ / 1000 * LED_PERIOD_MS;
    localparam int unsigned LED_ON_MS     = 50;
    localparam int unsigned LED_ON_CYC    = CLK_HZ / 1000 * LED_ON_MS;
    localparam int unsigned BIT_US        = 1000;
    localparam int unsigned BIT_CYC       = CLK_HZ / 1_000_000 * BIT_US;
    localparam int unsigned SCLK_DIV      = 20;

    // ------------------------------------------------------------
    // boot probe pattern
    // ------------------------------------------------------------
    localparam int unsigned PAT_LEN     = 16;
    localparam logic [15:0] PGM_PATTERN = 16'hB38D;

    // ------------------------------------------------------------
    // module contacts
    // ------------------------------------------------------------
    localparam int unsigned NUM_IO   = 6;
    localparam int unsigned IO_AUX   = 0;  // general contact; never spi out, as sdo_alt latches only in app mode and reset clears it
    localparam int unsigned IO_SS    = 1;  // spi slave select / uart tx
    localparam int unsigned IO_SCK   = 2;  // spi / i2c clock
    localparam int unsigned IO_SENSE = 3;  // pgm_sense_input, spi_data_in_pin
    localparam int unsigned IO_PROBE = 4;  // pgm_probe_output, spi_data_out_pin
    localparam int unsigned IO_WAKE  = 5;  // wakeup_change_pin
    localparam int unsigned BYTE_W   = 8;

    typedef enum {ST_BOOT, ST_APP, ST_PGM} bped_mode_t;
    typedef enum {H_IDLE, H_XFER, H_GAP} bped_host_st_t;

endpackage : bped_pkg

// >>> bped_link_if.sv
`timescale 1ns/1ps
interface bped_link_if;
    logic [bped_pkg::NUM_IO-1:0] dev_o;
    logic [bped_pkg::NUM_IO-1:0] dev_oe;
    logic [bped_pkg::NUM_IO-1:0] dev_pu;
    logic [bped_pkg::NUM_IO-1:0] host_o;
    logic [bped_pkg::NUM_IO-1:0] host_oe;
    logic [bped_pkg::NUM_IO-1:0] pin;

    // contact level: device, then host, then pull-up, else board pull-down
    // board pull-down default
    assign pin = (dev_oe & dev_o) | (~dev_oe & host_oe & host_o) | (~dev_oe & ~host_oe & dev_pu);

    modport dev (output dev_o, output dev_oe, output dev_pu, input pin);
    modport prg (output host_o, output host_oe, input pin);
endinterface : bped_link_if

// >>> bped_tick.sv
`timescale 1ns/1ps
module bped_tick #(
    parameter int unsigned DIV = 4
) (
    // clock and reset
    input  wire logic mclk_i,
    input  wire logic rst_i,
    // control
    input  wire logic en_i,
    output logic      tick_o
);
    localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;

    logic [CW-1:0] cnt;

    // one-cycle pulse every DIV cycles while enabled
    always_ff @(posedge mclk_i) begin
        if (rst_i || !en_i) begin
            cnt    <= '0;
            tick_o <= 1'b0;
        end else if (cnt == CW'(DIV - 1)) begin
            cnt    <= '0;
            tick_o <= 1'b1;
        end else begin
            cnt    <= cnt + 1'b1;
            tick_o <= 1'b0;
        end
    end
endmodule : bped_tick

// >>> bped_device.sv
`timescale 1ns/1ps
module bped_device #(
    parameter int unsigned BOOT_WIN   = bped_pkg::BOOT_WIN_CYC,
    parameter int unsigned BIT_LEN    = bped_pkg::BIT_CYC,
    parameter int unsigned LED_PERIOD = bped_pkg::LED_PERIOD_CYC,
    parameter int unsigned LED_ON     = bped_pkg::LED_ON_CYC
) (
    // clock and reset
    input  wire logic                        mclk_i,
    input  wire logic                        rst_i,
    // module contacts
    bped_link_if.dev                         link,
    // contact control
    input  wire logic [bped_pkg::NUM_IO-1:0] chg_en_i,
    input  wire logic [bped_pkg::NUM_IO-1:0] chg_clr_i,
    input  wire logic [bped_pkg::NUM_IO-1:0] pu_en_i,
    input  wire logic                        remap_sdo_i,
    input  wire logic                        rfu_enter_i,
    input  wire logic                        lprx_enter_i,
    // status
    output logic [bped_pkg::NUM_IO-1:0]      chg_flag_o,
    output logic                             wake_o,
    output logic                             rfu_mode_o,
    output logic                             lprx_mode_o,
    output logic                             boot_busy_o,
    output logic                             app_run_o,
    output logic                             pgm_mode_o,
    output logic                             led_red_o,
    // upload data
    output logic [bped_pkg::BYTE_W-1:0]      rx_data_o,
    output logic                             rx_valid_o
);
    localparam int unsigned IW = $clog2(bped_pkg::PAT_LEN);

    bped_pkg::bped_mode_t             mode;
    logic [bped_pkg::NUM_IO-1:0]      s1;
    logic [bped_pkg::NUM_IO-1:0]      s2;
    logic [bped_pkg::NUM_IO-1:0]      s3;
    logic [31:0]                      win_cnt;
    logic [31:0]                      led_cnt;
    logic [IW-1:0]                    bit_idx;
    logic [IW-1:0]                    match_cnt;
    logic                             bit_tick;
    logic                             probe_bit;
    logic                             echo_ok;
    logic                             echo_done;
    logic                             sel;
    logic                             sck_rise;
    logic                             sck_fall;
    logic [2:0]                       spi_cnt;
    logic [bped_pkg::BYTE_W-1:0]      rx_sr;
    logic [bped_pkg::BYTE_W-1:0]      sdo_sr;
    logic                             sdo_alt;
    logic [bped_pkg::NUM_IO-1:0]      drv_o;
    logic [bped_pkg::NUM_IO-1:0]      drv_oe;
    logic [bped_pkg::NUM_IO-1:0]      pu;

    // ------------------------------------------------------------
    // contact synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        s1 <= link.pin;
        s2 <= s1;
        s3 <= s2;
    end

    // ------------------------------------------------------------
    // boot detection
    // ------------------------------------------------------------
    bped_tick #(
        .DIV (BIT_LEN)
    ) u_bit_tick (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .en_i   (mode == bped_pkg::ST_BOOT),
        .tick_o (bit_tick)
    );

    assign probe_bit = bped_pkg::PGM_PATTERN[bit_idx];
    assign echo_ok   = (s2[bped_pkg::IO_SENSE] == probe_bit);
    assign echo_done = bit_tick && echo_ok && (match_cnt == IW'(bped_pkg::PAT_LEN - 1));

    // pattern position and run of matching bits, compared at end of bit
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            bit_idx   <= IW'(bped_pkg::PAT_LEN - 1);
            match_cnt <= '0;
        end else if (bit_tick) begin
            bit_idx   <= bit_idx - 1'b1;
            match_cnt <= echo_ok ? match_cnt + 1'b1 : '0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            win_cnt <= '0;
        end else if (mode == bped_pkg::ST_BOOT) begin
            win_cnt <= win_cnt + 1'b1;
        end
    end

    // mode selection and its status outputs
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            mode        <= bped_pkg::ST_BOOT;
            boot_busy_o <= 1'b1;
            app_run_o   <= 1'b0;
            pgm_mode_o  <= 1'b0;
        end else begin
            unique case (mode)
                bped_pkg::ST_BOOT: begin
                    if (echo_done) begin
                        mode        <= bped_pkg::ST_PGM;
                        boot_busy_o <= 1'b0;
                        pgm_mode_o  <= 1'b1;
                    end else if (win_cnt == 32'(BOOT_WIN - 1)) begin
                        mode        <= bped_pkg::ST_APP;
                        boot_busy_o <= 1'b0;
                        app_run_o   <= 1'b1;
                    end
                end
                bped_pkg::ST_APP: begin
                end
                bped_pkg::ST_PGM: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // programming mode indicator
    // ------------------------------------------------------------
    // brief flash each period
    always_ff @(posedge mclk_i) begin
        if (rst_i || mode != bped_pkg::ST_PGM) begin
            led_cnt   <= '0;
            led_red_o <= 1'b0;
        end else begin
            led_cnt   <= (led_cnt == 32'(LED_PERIOD - 1)) ? '0 : led_cnt + 1'b1;
            led_red_o <= (led_cnt < 32'(LED_ON));
        end
    end

    // ------------------------------------------------------------
    // spi upload slave, mode 0
    // ------------------------------------------------------------
    assign sel      = (mode == bped_pkg::ST_PGM) && !s2[bped_pkg::IO_SS];
    assign sck_rise = s2[bped_pkg::IO_SCK] && !s3[bped_pkg::IO_SCK];
    assign sck_fall = !s2[bped_pkg::IO_SCK] && s3[bped_pkg::IO_SCK];

    // shift upload bytes in from the sense contact
    always_ff @(posedge mclk_i) begin
        if (rst_i || !sel) begin
            spi_cnt    <= '0;
            rx_valid_o <= 1'b0;
            if (rst_i) begin
                rx_sr     <= '0;
                rx_data_o <= '0;
            end
        end else begin
            rx_valid_o <= 1'b0;
            if (sck_rise) begin
                rx_sr   <= {rx_sr[bped_pkg::BYTE_W-2:0], s2[bped_pkg::IO_SENSE]};
                spi_cnt <= spi_cnt + 1'b1;
                if (spi_cnt == 3'(bped_pkg::BYTE_W - 1)) begin
                    rx_data_o  <= {rx_sr[bped_pkg::BYTE_W-2:0], s2[bped_pkg::IO_SENSE]};
                    rx_valid_o <= 1'b1;
                end
            end
        end
    end

    // returns the last received byte, shifted on falling clock
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            sdo_sr <= '0;
        end else if (!sel) begin
            sdo_sr <= rx_data_o;
        end else if (sck_fall) begin
            sdo_sr <= {sdo_sr[bped_pkg::BYTE_W-2:0], 1'b0};
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            sdo_alt <= 1'b0;
        end else if (mode == bped_pkg::ST_APP) begin
            sdo_alt <= remap_sdo_i;
        end
    end

    // ------------------------------------------------------------
    // contact drivers and pull-ups
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            drv_o  <= '0;
            drv_oe <= '0;
        end else begin
            drv_o  <= '0;
            drv_oe <= '0;
            if (mode == bped_pkg::ST_BOOT) begin
                drv_oe[bped_pkg::IO_PROBE] <= 1'b1;
                drv_o[bped_pkg::IO_PROBE]  <= probe_bit;
            end else if (sel && !sdo_alt) begin
                drv_oe[bped_pkg::IO_PROBE] <= 1'b1;
                drv_o[bped_pkg::IO_PROBE]  <= sdo_sr[bped_pkg::BYTE_W-1];
            end else if (sel) begin
                drv_oe[bped_pkg::IO_AUX] <= 1'b1;
                drv_o[bped_pkg::IO_AUX]  <= sdo_sr[bped_pkg::BYTE_W-1];
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            pu <= '0;
        end else begin
            pu <= pu_en_i;
        end
    end

    assign link.dev_o  = drv_o;
    assign link.dev_oe = drv_oe;
    assign link.dev_pu = pu;

    // ------------------------------------------------------------
    // change flags and wake-up
    // ------------------------------------------------------------
    for (genvar gi = 0; gi < bped_pkg::NUM_IO; gi++) begin : g_chg
        always_ff @(posedge mclk_i) begin
            if (rst_i) begin
                chg_flag_o[gi] <= 1'b0;
            end else if (chg_en_i[gi] && (s2[gi] ^ s3[gi])) begin
                chg_flag_o[gi] <= 1'b1;
            end else if (chg_clr_i[gi]) begin
                chg_flag_o[gi] <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            wake_o      <= 1'b0;
            rfu_mode_o  <= 1'b0;
            lprx_mode_o <= 1'b0;
        end else begin
            wake_o <= s2[bped_pkg::IO_WAKE] ^ s3[bped_pkg::IO_WAKE];
            if (s2[bped_pkg::IO_WAKE] ^ s3[bped_pkg::IO_WAKE]) begin
                rfu_mode_o  <= 1'b0;
                lprx_mode_o <= 1'b0;
            end else begin
                rfu_mode_o  <= rfu_mode_o | rfu_enter_i;
                lprx_mode_o <= lprx_mode_o | lprx_enter_i;
            end
        end
    end
endmodule : bped_device

// >>> bped_host.sv
`timescale 1ns/1ps
module bped_host (
    // clock and reset
    input  wire logic                   mclk_i,
    input  wire logic                   rst_i,
    // module contacts
    bped_link_if.prg                    link,
    // user control
    input  wire logic                   pgm_req_i,
    input  wire logic                   wake_i,
    input  wire logic [bped_pkg::BYTE_W-1:0] tx_data_i,
    input  wire logic                   tx_valid_i,
    // user status
    output logic                        tx_ready_o,
    output logic [bped_pkg::BYTE_W-1:0] rx_data_o,
    output logic                        rx_valid_o
);
    bped_pkg::bped_host_st_t          st;
    logic [bped_pkg::NUM_IO-1:0]      h1;
    logic [bped_pkg::NUM_IO-1:0]      h2;
    logic [bped_pkg::BYTE_W-1:0]      sh;
    logic [bped_pkg::BYTE_W-1:0]      rsh;
    logic [2:0]                       bit_cnt;
    logic                             ss_n;
    logic                             sck;
    logic                             sck_tick;
    logic [bped_pkg::NUM_IO-1:0]      ho;
    logic [bped_pkg::NUM_IO-1:0]      hoe;

    // ------------------------------------------------------------
    // contact synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        h1 <= link.pin;
        h2 <= h1;
    end

    // ------------------------------------------------------------
    // spi upload master
    // ------------------------------------------------------------
    bped_tick #(
        .DIV (bped_pkg::SCLK_DIV)
    ) u_sck_tick (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .en_i   (st != bped_pkg::H_IDLE),
        .tick_o (sck_tick)
    );

    // one byte per select, gap before next
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            st         <= bped_pkg::H_IDLE;
            ss_n       <= 1'b1;
            sck        <= 1'b0;
            sh         <= '0;
            rsh        <= '0;
            bit_cnt    <= '0;
            tx_ready_o <= 1'b1;
            rx_data_o  <= '0;
            rx_valid_o <= 1'b0;
        end else begin
            rx_valid_o <= 1'b0;
            unique case (st)
                bped_pkg::H_IDLE: begin
                    if (tx_valid_i) begin
                        st         <= bped_pkg::H_XFER;
                        tx_ready_o <= 1'b0;
                        ss_n       <= 1'b0;
                        sh         <= tx_data_i;
                        bit_cnt    <= '0;
                    end
                end
                bped_pkg::H_XFER: begin
                    if (sck_tick && !sck) begin
                        sck <= 1'b1;
                        rsh <= {rsh[bped_pkg::BYTE_W-2:0], h2[bped_pkg::IO_PROBE]};
                    end else if (sck_tick) begin
                        sck     <= 1'b0;
                        sh      <= {sh[bped_pkg::BYTE_W-2:0], 1'b0};
                        bit_cnt <= bit_cnt + 1'b1;
                        if (bit_cnt == 3'(bped_pkg::BYTE_W - 1)) begin
                            st         <= bped_pkg::H_GAP;
                            ss_n       <= 1'b1;
                            rx_data_o  <= rsh;
                            rx_valid_o <= 1'b1;
                        end
                    end
                end
                bped_pkg::H_GAP: begin
                    if (sck_tick) begin
                        st         <= bped_pkg::H_IDLE;
                        tx_ready_o <= 1'b1;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // contact drivers
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ho  <= '0;
            hoe <= '0;
        end else begin
            hoe                      <= '0;
            ho                       <= '0;
            hoe[bped_pkg::IO_SS]     <= 1'b1;
            ho[bped_pkg::IO_SS]      <= ss_n;
            hoe[bped_pkg::IO_SCK]    <= 1'b1;
            ho[bped_pkg::IO_SCK]     <= sck;
            hoe[bped_pkg::IO_WAKE]   <= 1'b1;
            ho[bped_pkg::IO_WAKE]    <= wake_i;
            // sense always driven to a level
            hoe[bped_pkg::IO_SENSE]  <= 1'b1;
            if (st != bped_pkg::H_IDLE) begin
                ho[bped_pkg::IO_SENSE] <= sh[bped_pkg::BYTE_W-1];
            end else if (pgm_req_i) begin
                ho[bped_pkg::IO_SENSE] <= h2[bped_pkg::IO_PROBE];
            end
        end
    end

    assign link.host_o  = ho;
    assign link.host_oe = hoe;
endmodule : bped_host

// >>> bped_chk.sv
`timescale 1ns/1ps
module bped_chk (
    // clock and reset
    input  wire logic                        mclk_i,
    input  wire logic                        rst_i,
    // contact signals
    input  wire logic [bped_pkg::NUM_IO-1:0] dev_o,
    input  wire logic [bped_pkg::NUM_IO-1:0] dev_oe,
    input  wire logic [bped_pkg::NUM_IO-1:0] dev_pu,
    input  wire logic [bped_pkg::NUM_IO-1:0] host_o,
    input  wire logic [bped_pkg::NUM_IO-1:0] host_oe,
    input  wire logic [bped_pkg::NUM_IO-1:0] pin
);
    localparam int unsigned PR = bped_pkg::IO_PROBE;
    localparam int unsigned SE = bped_pkg::IO_SENSE;
    localparam int unsigned SS = bped_pkg::IO_SS;
    localparam int unsigned SK = bped_pkg::IO_SCK;

    // ------------------------------------------------------------
    // link checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    AST_PIN_LEVEL: assert property (pin == ((dev_oe & dev_o) | (~dev_oe & host_oe & host_o)
        | (~dev_oe & ~host_oe & dev_pu))) else $error("contact level wrong");
    AST_PROBE_DRIVEN: assert property ($fell(rst_i) |-> ##[1:3] dev_oe[PR])
        else $error("probe not driven after reset");
    AST_FIRST_BIT: assert property ($fell(rst_i) |-> ##[1:3]
        (dev_oe[PR] && dev_o[PR] == bped_pkg::PGM_PATTERN[bped_pkg::PAT_LEN - 1]))
        else $error("first probe bit wrong");
    // probe bit holds at least 9 cycles
    AST_BIT_HOLD: assert property (($changed(dev_o[PR]) && dev_oe[PR]) |=>
        (!dev_oe[PR] || $stable(dev_o[PR])) [*8]) else $error("probe bit too short");
    // sense is an input of the device
    AST_SENSE_INPUT: assert property (!dev_oe[SE]) else $error("device drives sense");
    AST_PROBE_NOT_HOST: assert property (!host_oe[PR]) else $error("host drives probe");
    AST_SENSE_DEFINED: assert property (!$fell(host_oe[SE])) else $error("sense released");
    AST_SCK_IN_FRAME: assert property ($rose(host_o[SK]) |-> (host_oe[SS] && !host_o[SS]))
        else $error("clock outside frame");
    AST_SCK_IDLE: assert property (host_o[SS] |-> !host_o[SK]) else $error("clock not idle");
endmodule : bped_chk

// >>> tb_boot_program_entry_detect.sv
`timescale 1ns/1ps
`define CHK(act, exp, msg) begin n_compared++; if ((act) !== (exp)) begin miscompares++; \
    $display("Error at %0t: %s", $time, msg); end end
`define WAITHI(s, lim) begin k = 0; while ((s) !== 1'b1) begin @(posedge mclk_i); #1; k++; \
    if (k > (lim)) begin miscompares++; $display("Error at %0t: wait timed out", $time); complete_run(); end end end
module tb_boot_program_entry_detect;
    localparam int BW = 2000;
    localparam int BL = 20;
    localparam int LP = 400;
    localparam int LO = 40;
    logic                        mclk_i     = 1'b0;
    logic                        rst_i      = 1'b1;
    logic [bped_pkg::NUM_IO-1:0] chg_en     = '0;
    logic [bped_pkg::NUM_IO-1:0] chg_clr    = '0;
    logic [bped_pkg::NUM_IO-1:0] pu_en      = '0;
    logic                        remap_sdo  = 1'b0;
    logic                        rfu_enter  = 1'b0;
    logic                        lprx_enter = 1'b0;
    logic                        pgm_req    = 1'b0;
    logic                        wake       = 1'b0;
    logic                        tx_valid   = 1'b0;
    logic [7:0]                  tx_data    = 8'h00;
    logic [bped_pkg::NUM_IO-1:0] chg_flag;
    logic                        wake_p, rfu_mode, lprx_mode, boot_busy, app_run, pgm_mode, led_red;
    logic                        d_rx_valid, h_rx_valid, tx_ready;
    logic [7:0]                  d_rx_data, h_rx_data;
    int                          miscompares = 0;
    int                          n_compared  = 0;
    int                          k;

    // clock and parts
    always #12.5 mclk_i = ~mclk_i;
    bped_link_if bped_link_if_i ();
    bped_device #(.BOOT_WIN(BW), .BIT_LEN(BL), .LED_PERIOD(LP), .LED_ON(LO)) bped_device_i (
        .mclk_i(mclk_i), .rst_i(rst_i), .link(bped_link_if_i), .chg_en_i(chg_en), .chg_clr_i(chg_clr),
        .pu_en_i(pu_en), .remap_sdo_i(remap_sdo), .rfu_enter_i(rfu_enter), .lprx_enter_i(lprx_enter),
        .chg_flag_o(chg_flag), .wake_o(wake_p), .rfu_mode_o(rfu_mode), .lprx_mode_o(lprx_mode),
        .boot_busy_o(boot_busy), .app_run_o(app_run), .pgm_mode_o(pgm_mode), .led_red_o(led_red),
        .rx_data_o(d_rx_data), .rx_valid_o(d_rx_valid));
    bped_host bped_host_i (
        .mclk_i(mclk_i), .rst_i(rst_i), .link(bped_link_if_i), .pgm_req_i(pgm_req), .wake_i(wake),
        .tx_data_i(tx_data), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready), .rx_data_o(h_rx_data),
        .rx_valid_o(h_rx_valid));
    bped_chk bped_chk_i (
        .mclk_i(mclk_i), .rst_i(rst_i), .dev_o(bped_link_if_i.dev_o), .dev_oe(bped_link_if_i.dev_oe),
        .dev_pu(bped_link_if_i.dev_pu), .host_o(bped_link_if_i.host_o), .host_oe(bped_link_if_i.host_oe),
        .pin(bped_link_if_i.pin));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task complete_run();
        $display("compared %0d, mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run

    task do_reset();
        @(posedge mclk_i) rst_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        rst_i <= 1'b0;
    endtask : do_reset

    // one byte from host; dev_on says whether the device takes it
    task automatic xfer(input logic [7:0] d, input logic [7:0] exp_host, input bit dev_on);
        int         seen;
        logic [7:0] dcap;
        seen = 0;
        dcap = 8'h00;
        `WAITHI(tx_ready, 100)
        @(posedge mclk_i) tx_data <= d;
        tx_valid <= 1'b1;
        @(posedge mclk_i) tx_valid <= 1'b0;
        k = 0;
        while (h_rx_valid !== 1'b1) begin
            @(posedge mclk_i); #1; k++;
            if (d_rx_valid === 1'b1) begin seen++; dcap = d_rx_data; end
            if (k > 800) begin miscompares++; $display("Error at %0t: no byte back", $time); complete_run(); end
        end
        `CHK(seen, (dev_on ? 1 : 0), "device byte count") // upload gate
        if (dev_on) `CHK(dcap, d, "device byte") // received byte
        `CHK(h_rx_data, exp_host, "returned byte") // data out contact
        $display("spi byte %0h done", d);
    endtask : xfer

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic boot_app();
        do_reset();
        repeat (12) @(posedge mclk_i);
        #1 `CHK(boot_busy, 1'b1, "not in detection") // detection window
        for (int i = 0; i < 16; i++) begin
            #1 `CHK(bped_link_if_i.pin[bped_pkg::IO_PROBE], bped_pkg::PGM_PATTERN[15-i], "probe bit") // pattern
            repeat (BL) @(posedge mclk_i);
        end
        `WAITHI(app_run, BW)
        `CHK(((332 + k) >= BW - 2) && ((332 + k) <= BW + 3), 1'b1, "window length") // window length
        repeat (2) @(posedge mclk_i);
        #1 `CHK(pgm_mode, 1'b0, "unexpected programming mode") // no echo
        `CHK(bped_link_if_i.dev_oe[bped_pkg::IO_PROBE], 1'b0, "probe still driven") // probe released
        $display("boot to application done");
    endtask : boot_app

    task automatic contacts();
        @(posedge mclk_i) chg_en <= '1;
        remap_sdo <= 1'b1;
        rfu_enter <= 1'b1;
        lprx_enter <= 1'b1;
        pu_en[bped_pkg::IO_AUX] <= 1'b1;
        @(posedge mclk_i) rfu_enter <= 1'b0;
        lprx_enter <= 1'b0;
        @(posedge mclk_i) #1 `CHK({rfu_mode, lprx_mode}, 2'b11, "mode not entered") // modes set
        `CHK(bped_link_if_i.pin[bped_pkg::IO_AUX], 1'b1, "pull-up missing") // pull-up
        @(posedge mclk_i) wake <= 1'b1;
        pu_en <= '0;
        `WAITHI(wake_p, 10)
        repeat (2) @(posedge mclk_i);
        #1 `CHK({rfu_mode, lprx_mode}, 2'b00, "mode not ended") // wake ends modes
        `CHK(chg_flag[bped_pkg::IO_WAKE], 1'b1, "change flag") // change flag
        `CHK(bped_link_if_i.pin[bped_pkg::IO_AUX], 1'b0, "pull-down level") // pull-down
        @(posedge mclk_i) chg_clr[bped_pkg::IO_WAKE] <= 1'b1;
        @(posedge mclk_i) chg_clr <= '0;
        @(posedge mclk_i) #1 `CHK(chg_flag[bped_pkg::IO_WAKE], 1'b0, "flag not cleared") // clear
        // change while clear is held: set wins that cycle
        @(posedge mclk_i) wake <= 1'b0;
        chg_clr[bped_pkg::IO_WAKE] <= 1'b1;
        `WAITHI(wake_p, 10)
        `CHK(chg_flag[bped_pkg::IO_WAKE], 1'b1, "set lost to clear") // set wins
        @(posedge mclk_i) chg_clr <= '0;
        #1 `CHK(chg_flag[bped_pkg::IO_WAKE], 1'b0, "held clear ignored") // clear
        $display("contact checks done");
    endtask : contacts

    task automatic pgm_entry();
        int highs;
        highs = 0;
        @(posedge mclk_i) pgm_req <= 1'b1;
        do_reset();
        `WAITHI(pgm_mode, BW)
        `CHK(k <= 17 * BL + 10, 1'b1, "echo entry late") // echo entry
        `CHK(app_run, 1'b0, "application started") // bootloader chosen
        @(posedge mclk_i) pgm_req <= 1'b0;
        `WAITHI(led_red, LP + 5)
        for (int j = 0; j < 2 * LP; j++) begin
            if (led_red === 1'b1) highs++;
            @(posedge mclk_i); #1;
        end
        `CHK(highs, 2 * LO, "led duty") // led flash
        $display("programming entry done");
    endtask : pgm_entry

    // main sequence
    initial begin
        boot_app();
        contacts();
        xfer(8'h77, 8'h00, 1'b0);
        pgm_entry();
        xfer(8'hA5, 8'h00, 1'b1);
        xfer(8'h3C, 8'hA5, 1'b1);
        complete_run();
    end
endmodule : tb_boot_program_entry_detect
